// ---- sch_sanitize.v ----
// sanitize command decoder, state machine and overwrite engine
`timescale 1ns/100ps
`include "sch_regs.vh"
module sch_sanitize (
   // clock and reset
   input  wire        i_clk,
   input  wire        i_sys_rst,
   // reset events and feature strap
   input  wire        i_por_event,
   input  wire        i_hard_reset,
   input  wire        i_sanitize_supported,
   input  wire        i_freeze_lock_done,
   // task-file command
   input  wire        i_cmd_valid,
   input  wire [7:0]  i_command,
   input  wire [15:0] i_feature,
   input  wire [15:0] i_count,
   input  wire [7:0]  i_sect_num_prev,
   input  wire [7:0]  i_cyl_hi_cur,
   input  wire [7:0]  i_cyl_lo_cur,
   input  wire [7:0]  i_sect_num_cur,
   // task-file answer
   output reg         o_cmd_done,
   output reg  [7:0]  o_command_error_flags,
   output reg  [7:0]  o_device_status_flags,
   output reg  [15:0] o_ret_count,
   output reg  [7:0]  o_ret_cyl_lo,
   output reg  [7:0]  o_ret_sect_num,
   // media write port
   output wire        o_wr_valid,
   output wire [`SCH_BLK_W-1:0] o_wr_block,
   output wire [31:0] o_wr_pattern,
   input  wire        i_wr_ready,
   input  wire        i_wr_fault
);

   ////////////////////////////////////////////////////////////////////////
   // sanitize states
   localparam [2:0] SANITIZE_IDLE_STATE      = 3'h0;
   localparam [2:0] SANITIZE_FROZEN_STATE    = 3'h1;
   localparam [2:0] SANITIZE_RUNNING_STATE   = 3'h2;
   localparam [2:0] SANITIZE_FAILED_STATE    = 3'h3;
   localparam [2:0] SANITIZE_SUCCEEDED_STATE = 3'h4;

   ////////////////////////////////////////////////////////////////////////
   // state and bookkeeping
   reg  [2:0]            state;          // sanitize state
   reg                   completed_ok;   // last sanitize succeeded
   reg                   freeze_seen;    // freeze lock since power-on
   reg                   failed_policy;  // policy of the running op
   reg                   invert_en;      // invert between passes
   reg  [4:0]            pass_total;     // passes requested, 1..16
   reg  [4:0]            pass_idx;       // passes finished
   reg  [`SCH_BLK_W-1:0] blk;            // next block to write
   reg                   fault_seen;     // a block failed to write
   reg  [15:0]           progress;       // running progress numerator

   // decode results
   wire is_sanitize  = i_cmd_valid && (i_command == `SCH_CMD_SANITIZE);
   wire feat_status  = (i_feature == `SCH_FEAT_STATUS);
   wire feat_over    = (i_feature == `SCH_FEAT_OVERWRITE);
   wire req_policy   = i_count[`SCH_CNT_POLICY_BIT];
   wire [3:0] req_passes = i_count[`SCH_CNT_PASSES_HI:`SCH_CNT_PASSES_LO];
   // request pattern as the host lays it out; fed to the
   // generator directly so the first beat needs no extra stage
   wire [31:0] req_pattern = {i_sect_num_prev, i_cyl_hi_cur,
                              i_cyl_lo_cur, i_sect_num_cur};
   wire running      = (state == SANITIZE_RUNNING_STATE);
   wire frozen       = (state == SANITIZE_FROZEN_STATE);
   wire failed       = (state == SANITIZE_FAILED_STATE);

   // write beat and end-of-area detection
   wire wr_fire      = o_wr_valid && i_wr_ready;
   wire last_blk     = (blk == {`SCH_BLK_W{1'b1}});
   wire pass_end     = wr_fire && last_blk;
   wire last_pass    = (pass_idx + 5'h01 == pass_total);

   ////////////////////////////////////////////////////////////////////////
   // abort decision and reason for a sanitize command
   reg       next_abort;   // command is refused
   reg [7:0] next_reason;  // reason code for the refusal
   reg       start_over;   // overwrite is accepted
   reg       exit_failed;  // status command leaves failed state

   always @* begin
      next_abort  = 1'b0;
      next_reason = `SCH_REASON_NONE;
      start_over  = 1'b0;
      exit_failed = 1'b0;
      if (!feat_status && !feat_over) begin
         next_abort  = 1'b1;
         next_reason = `SCH_REASON_BADFEAT;
      end else if (feat_status) begin
         if (failed && failed_policy) begin
            // policy set lets status exit failed
            exit_failed = 1'b1;
         end else if (failed) begin
            // failure stays reported until the state is left
            next_abort  = 1'b1;
            next_reason = `SCH_REASON_UNSANE;
         end
      end else if (frozen || freeze_seen) begin
         next_abort  = 1'b1;
         next_reason = `SCH_REASON_FROZEN;
      end else if (!i_sanitize_supported) begin
         next_abort  = 1'b1;
         next_reason = `SCH_REASON_BADFEAT;
      end else if (running) begin
         // only idle, failed or succeeded accept
         next_abort  = 1'b1;
      end else if (failed && !failed_policy && req_policy) begin
         // strict failure blocks a lenient retry
         // held until a strict retry or a freeze lock leaves the failed state
         next_abort  = 1'b1;
      end else begin
         // b4h with feature 0014h is an overwrite
         start_over  = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sanitize state machine
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         state <= SANITIZE_IDLE_STATE;
      end else if ((i_por_event || i_hard_reset) && frozen) begin
         // frozen falls back to idle on reset
         // other states let the event pass, so a run that sees one
         // on its last beat still reaches its final state
         state <= SANITIZE_IDLE_STATE;
      end else begin
         case (state)
            SANITIZE_RUNNING_STATE: begin
               // final state only after the last pass ends
               if (pass_end && last_pass) begin
                  if (fault_seen || i_wr_fault) begin
                     state <= SANITIZE_FAILED_STATE;
                  end else begin
                     state <= SANITIZE_SUCCEEDED_STATE;
                  end
               end
            end
            SANITIZE_FROZEN_STATE: begin
               // only a reset leaves frozen
               state <= SANITIZE_FROZEN_STATE;
            end
            default: begin
               if (i_freeze_lock_done) begin
                  state <= SANITIZE_FROZEN_STATE;
               end else if (is_sanitize && start_over) begin
                  state <= SANITIZE_RUNNING_STATE;
               end else if (is_sanitize && exit_failed) begin
                  state <= SANITIZE_IDLE_STATE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // freeze history, cleared only by power-on or a full logic reset
   // a hardware reset leaves it set, so frozen is left but refusals stay
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         freeze_seen <= 1'b0;
      end else if (i_freeze_lock_done && !running) begin
         // set wins over a simultaneous power-on clear
         freeze_seen <= 1'b1;
      end else if (i_por_event) begin
         freeze_seen <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // completion flag, kept across power-on events
   // only a full logic reset clears it outside a new request
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         completed_ok <= 1'b0;
      end else if (is_sanitize && start_over && !running) begin
         completed_ok <= 1'b0;
      end else if (running && pass_end && last_pass) begin
         completed_ok <= !(fault_seen || i_wr_fault);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // capture of the overwrite request
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         failed_policy <= 1'b0;
         invert_en     <= 1'b0;
         pass_total    <= 5'h10;
      end else if (is_sanitize && start_over && !running) begin
         failed_policy <= req_policy;
         invert_en     <= i_count[`SCH_CNT_INVERT_BIT];
         pass_total    <= (req_passes == 4'h0) ? 5'h10
                                               : {1'b0, req_passes};
         // the pattern itself goes straight to the generator
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // block and pass counters of the overwrite engine
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         blk        <= {`SCH_BLK_W{1'b0}};
         pass_idx   <= 5'h00;
         fault_seen <= 1'b0;
      end else if (is_sanitize && start_over && !running) begin
         blk        <= {`SCH_BLK_W{1'b0}};
         pass_idx   <= 5'h00;
         fault_seen <= 1'b0;
      end else if (running && wr_fire) begin
         // walk every block of the user area
         blk <= blk + {{(`SCH_BLK_W-1){1'b0}}, 1'b1};
         if (last_blk) begin
            pass_idx <= pass_idx + 5'h01;
         end
         if (i_wr_fault) begin
            fault_seen <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pattern register, inverted at each pass boundary
   wire pat_load = is_sanitize && start_over && !running;

   // loaded at the very edge that starts the run, so the first
   // beat already carries the requested pattern
   sch_pattern_gen u_pattern (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_load    (pat_load),
      .i_step    (pass_end),
      .i_invert  (invert_en),
      .i_base    (req_pattern),
      .o_pattern (o_wr_pattern)
   );

   // write port drives while running
   assign o_wr_valid = running;
   assign o_wr_block = blk;

   ////////////////////////////////////////////////////////////////////////
   // reciprocal of the pass count, scaled by 65536
   // entries round down, so progress stays below full until the end
   function [16:0] recip;
      input [4:0] n;
      begin
         case (n)
            5'h01:   recip = 17'h10000;
            5'h02:   recip = 17'h08000;
            5'h03:   recip = 17'h05555;
            5'h04:   recip = 17'h04000;
            5'h05:   recip = 17'h03333;
            5'h06:   recip = 17'h02aaa;
            5'h07:   recip = 17'h02492;
            5'h08:   recip = 17'h02000;
            5'h09:   recip = 17'h01c71;
            5'h0a:   recip = 17'h01999;
            5'h0b:   recip = 17'h01745;
            5'h0c:   recip = 17'h01555;
            5'h0d:   recip = 17'h013b1;
            5'h0e:   recip = 17'h01249;
            5'h0f:   recip = 17'h01111;
            default: recip = 17'h01000;
         endcase
      end
   endfunction

   // blocks written so far and scaled fraction; the beat taken
   // this cycle is counted so the value never lags the media
   wire [16:0] units = {pass_idx[3:0], blk} +
                       {16'h0000, wr_fire};
   wire [33:0] scaled = units * recip(pass_total);

   ////////////////////////////////////////////////////////////////////////
   // progress numerator over 65536
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         progress <= 16'h0000;
      end else if (pat_load) begin
         progress <= 16'h0000;
      end else if (running && pass_end && last_pass) begin
         // complete on the same edge that the final state is entered
         progress <= `SCH_PROGRESS_IDLE;
      end else if (running && wr_fire) begin
         progress <= scaled[27:12];
      end
   end

   // all ones outside the running state
   wire [15:0] progress_out = running ? progress : `SCH_PROGRESS_IDLE;

   ////////////////////////////////////////////////////////////////////////
   // answer registers, loaded one cycle after a sanitize command
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_cmd_done            <= 1'b0;
         o_command_error_flags <= `SCH_ERR_RESET;
         o_device_status_flags <= `SCH_STS_RESET;
         o_ret_count           <= 16'h0000;
         o_ret_cyl_lo          <= 8'hff;
         o_ret_sect_num        <= 8'hff;
      end else begin
         o_cmd_done <= is_sanitize;
         if (is_sanitize) begin
            o_ret_count <= 16'h0000;
            o_ret_count[`SCH_RET_OK_BIT]     <= completed_ok;
            o_ret_count[`SCH_RET_RUN_BIT]    <= running || start_over;
            o_ret_count[`SCH_RET_FROZEN_BIT] <= frozen;
            // progress bytes split over two registers
            o_ret_cyl_lo <= progress_out[15:8];
            o_ret_sect_num <= progress_out[7:0];
            o_command_error_flags <= `SCH_ERR_RESET;
            o_device_status_flags <= `SCH_STS_RESET;
            o_device_status_flags[`SCH_STS_DSC_BIT] <= 1'b1;
            if (next_abort) begin
               // reason code replaces low progress byte
               o_ret_sect_num <= next_reason;
               o_command_error_flags[`SCH_ERR_ABORT_BIT] <= 1'b1;
               o_device_status_flags[`SCH_STS_ERR_BIT] <= 1'b1;
            end
         end
      end
   end

endmodule

// ---- sch_regs.vh ----
// constants for the sanitize command handler
`ifndef SCH_REGS_VH
`define SCH_REGS_VH

// command and feature codes
`define SCH_CMD_SANITIZE     8'hb4
`define SCH_FEAT_STATUS      16'h0000
`define SCH_FEAT_OVERWRITE   16'h0014

// count field positions of the overwrite request
`define SCH_CNT_INVERT_BIT   7
`define SCH_CNT_POLICY_BIT   4
`define SCH_CNT_PASSES_HI    3
`define SCH_CNT_PASSES_LO    0

// returned count field positions
`define SCH_RET_OK_BIT       15
`define SCH_RET_RUN_BIT      14
`define SCH_RET_FROZEN_BIT   13

// progress value when no overwrite runs
`define SCH_PROGRESS_IDLE    16'hffff

// error reason codes
`define SCH_REASON_NONE      8'h00
`define SCH_REASON_UNSANE    8'h01
`define SCH_REASON_BADFEAT   8'h02
`define SCH_REASON_FROZEN    8'h03

// error and status register bit positions
`define SCH_ERR_ABORT_BIT    2
`define SCH_STS_ERR_BIT      0
`define SCH_STS_DSC_BIT      4
`define SCH_STS_RDY_BIT      6

// reset values
`define SCH_ERR_RESET        8'h00
`define SCH_STS_RESET        8'h40

// user area size, as log2 of block count
`define SCH_BLK_W            12

`endif

// ---- sch_pattern_gen.v ----
// overwrite pattern register with per-pass inversion
`timescale 1ns/100ps
module sch_pattern_gen (
   // clock and reset
   input  wire        i_clk,
   input  wire        i_sys_rst,
   // control
   input  wire        i_load,
   input  wire        i_step,
   input  wire        i_invert,
   input  wire [31:0] i_base,
   // pattern out
   output reg  [31:0] o_pattern
);

   ////////////////////////////////////////////////////////////////////////
   // pattern follows the pass counter; load wins over a pass step
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_pattern <= 32'h00000000;
      end else if (i_load) begin
         // first pass always writes the pattern as given
         o_pattern <= i_base;
      end else if (i_step && i_invert) begin
         o_pattern <= ~o_pattern;
      end
   end

endmodule

// ---- sch_sanitize_props.sv ----
// concurrent checks on the sanitize handler ports
`timescale 1ns/100ps
`include "sch_regs.vh"
module sch_sanitize_props (
   // clock and reset
   input wire        i_clk,
   input wire        i_sys_rst,
   // command side
   input wire        i_sanitize_supported,
   input wire        i_cmd_valid,
   input wire [7:0]  i_command,
   input wire [15:0] i_feature,
   input wire [15:0] i_count,
   input wire [7:0]  i_sect_num_prev,
   input wire [7:0]  i_cyl_hi_cur,
   input wire [7:0]  i_cyl_lo_cur,
   input wire [7:0]  i_sect_num_cur,
   // answer side
   input wire        o_cmd_done,
   input wire [7:0]  o_command_error_flags,
   input wire [7:0]  o_device_status_flags,
   input wire [15:0] o_ret_count,
   input wire [7:0]  o_ret_cyl_lo,
   input wire [7:0]  o_ret_sect_num,
   // media side
   input wire        o_wr_valid,
   input wire [11:0] o_wr_block,
   input wire [31:0] o_wr_pattern,
   input wire        i_wr_ready
);
   wire is_cmd = i_cmd_valid && (i_command == `SCH_CMD_SANITIZE);
   wire is_ow  = is_cmd && (i_feature == `SCH_FEAT_OVERWRITE);
   wire abort_error_flag    = o_command_error_flags[`SCH_ERR_ABORT_BIT];
   reg  inv_req; // invert request of the overwrite that may start
   // capture invert bit only when nothing runs, refused ones never start
   always @(posedge i_clk) begin
      if (i_sys_rst)
         inv_req <= 1'b0;
      else if (is_ow && !o_wr_valid)
         inv_req <= i_count[7];
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   sequence s_ow_start;
      is_ow && !o_wr_valid ##1 o_wr_valid;
   endsequence
   sequence s_pass_end;
      o_wr_valid && i_wr_ready && (o_wr_block == 12'hfff);
   endsequence
   property p_done;
      is_cmd |=> o_cmd_done;
   endproperty
   property p_prog_idle;
      o_cmd_done && !abort_error_flag && !o_ret_count[14]
      |-> {o_ret_cyl_lo, o_ret_sect_num} == `SCH_PROGRESS_IDLE;
   endproperty
   property p_abort_flags;
      o_cmd_done |-> abort_error_flag == o_device_status_flags[`SCH_STS_ERR_BIT];
   endproperty
   property p_feat;
      is_cmd && (i_feature != 16'h0000) && (i_feature != 16'h0014)
      |=> abort_error_flag && (o_ret_sect_num == `SCH_REASON_BADFEAT);
   endproperty
   property p_unsup;
      is_ow && !i_sanitize_supported |=> abort_error_flag;
   endproperty
   property p_run_abort;
      is_ow && o_wr_valid |=> abort_error_flag && (o_ret_sect_num == 8'h00);
   endproperty
   property p_start;
      s_ow_start |-> (o_wr_block == 12'h000) && (o_wr_pattern ==
         $past({i_sect_num_prev, i_cyl_hi_cur, i_cyl_lo_cur, i_sect_num_cur}));
   endproperty
   property p_step;
      o_wr_valid && i_wr_ready && (o_wr_block != 12'hfff)
      |=> o_wr_block == $past(o_wr_block) + 12'h001;
   endproperty
   property p_stall;
      o_wr_valid && !i_wr_ready |=> $stable(o_wr_block) && $stable(o_wr_pattern);
   endproperty
   property p_invert;
      s_pass_end ##1 o_wr_valid |-> o_wr_pattern ==
         (inv_req ? ~$past(o_wr_pattern) : $past(o_wr_pattern));
   endproperty
   a_done:        assert property (p_done) else $error("no done after command");
   a_prog_idle:   assert property (p_prog_idle) else $error("progress not idle");
   a_abort_flags: assert property (p_abort_flags) else $error("abort flags split");
   a_feat:        assert property (p_feat) else $error("bad feature accepted");
   a_unsup:       assert property (p_unsup) else $error("unsupported accepted");
   a_run_abort:   assert property (p_run_abort) else $error("run not aborted");
   a_start:       assert property (p_start) else $error("bad start beat");
   a_step:        assert property (p_step) else $error("block skipped");
   a_stall:       assert property (p_stall) else $error("beat moved in stall");
   a_invert:      assert property (p_invert) else $error("pass pattern wrong");
endmodule
bind sch_sanitize sch_sanitize_props u_props (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_sanitize_supported(i_sanitize_supported), .i_cmd_valid(i_cmd_valid),
   .i_command(i_command), .i_feature(i_feature), .i_count(i_count),
   .i_sect_num_prev(i_sect_num_prev), .i_cyl_hi_cur(i_cyl_hi_cur),
   .i_cyl_lo_cur(i_cyl_lo_cur), .i_sect_num_cur(i_sect_num_cur),
   .o_cmd_done(o_cmd_done), .o_command_error_flags(o_command_error_flags),
   .o_device_status_flags(o_device_status_flags), .o_ret_count(o_ret_count),
   .o_ret_cyl_lo(o_ret_cyl_lo), .o_ret_sect_num(o_ret_sect_num),
   .o_wr_valid(o_wr_valid), .o_wr_block(o_wr_block),
   .o_wr_pattern(o_wr_pattern), .i_wr_ready(i_wr_ready));

// ---- sch_media_model.sv ----
// behavioural media write port that can stall and fail a block
`timescale 1ns/100ps
module sch_media_model (
   // clock
   input  wire        i_clk,
   // write port from the handler
   input  wire        i_wr_valid,
   input  wire [11:0] i_wr_block,
   input  wire [31:0] i_wr_pattern,
   // bench controls
   input  wire        i_stall,
   input  wire        i_fault,
   // answers and tallies
   output reg         o_wr_ready,
   output reg         o_wr_fault,
   output reg  [31:0] o_beats,
   output reg  [31:0] o_pass_pat
);
   reg tog; // half-rate ready while stalling
   initial begin
      o_wr_ready = 1'b1;
      o_wr_fault = 1'b0;
      o_beats = 32'h0;
      o_pass_pat = 32'h0;
      tog = 1'b0;
   end
   // count accepted beats, keep the pattern each pass opens with
   always @(posedge i_clk) begin
      if (i_wr_valid && o_wr_ready) begin
         o_beats <= o_beats + 32'h1;
         if (i_wr_block == 12'h000)
            o_pass_pat <= i_wr_pattern;
      end
   end
   // answers move off the sampling edge; fault only on block 5
   always @(negedge i_clk) begin
      tog <= ~tog;
      o_wr_ready <= ~i_stall | tog;
      o_wr_fault <= i_fault && (i_wr_block == 12'h005);
   end
endmodule

// ---- tb_top.sv ----
// self-checking bench for the sanitize handler
`timescale 1ns/100ps
module tb_top;
   reg         i_clk, i_sys_rst, i_por_event, i_hard_reset, i_sanitize_supported;
   reg         i_freeze_lock_done, i_cmd_valid, stall, fault;
   reg  [7:0]  i_command, i_sect_num_prev, i_cyl_hi_cur, i_cyl_lo_cur, i_sect_num_cur;
   reg  [15:0] i_feature, i_count;
   wire        o_cmd_done, o_wr_valid, wr_ready, wr_fault;
   wire [7:0]  o_command_error_flags, o_device_status_flags, o_ret_cyl_lo, o_ret_sect_num;
   wire [15:0] o_ret_count;
   wire [11:0] o_wr_block;
   wire [31:0] o_wr_pattern, beats, pass_pat;
   integer     fail_count, cmp_count, n;
   reg  [31:0] b0, p1;
   sch_sanitize dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_por_event(i_por_event),
      .i_hard_reset(i_hard_reset), .i_sanitize_supported(i_sanitize_supported),
      .i_freeze_lock_done(i_freeze_lock_done), .i_cmd_valid(i_cmd_valid),
      .i_command(i_command), .i_feature(i_feature), .i_count(i_count),
      .i_sect_num_prev(i_sect_num_prev), .i_cyl_hi_cur(i_cyl_hi_cur),
      .i_cyl_lo_cur(i_cyl_lo_cur), .i_sect_num_cur(i_sect_num_cur),
      .o_cmd_done(o_cmd_done), .o_command_error_flags(o_command_error_flags),
      .o_device_status_flags(o_device_status_flags), .o_ret_count(o_ret_count),
      .o_ret_cyl_lo(o_ret_cyl_lo), .o_ret_sect_num(o_ret_sect_num),
      .o_wr_valid(o_wr_valid), .o_wr_block(o_wr_block), .o_wr_pattern(o_wr_pattern),
      .i_wr_ready(wr_ready), .i_wr_fault(wr_fault));
   sch_media_model u_media (.i_clk(i_clk), .i_wr_valid(o_wr_valid),
      .i_wr_block(o_wr_block), .i_wr_pattern(o_wr_pattern), .i_stall(stall),
      .i_fault(fault), .o_wr_ready(wr_ready), .o_wr_fault(wr_fault),
      .o_beats(beats), .o_pass_pat(pass_pat));
   always #4 i_clk = ~i_clk;
   ////////////////////////////////////////////////////////////////////////
   // compare, tally, report
   task check(input [31:0] got, input [31:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task complete_run;
   begin
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   // one task-file command; done must follow sanitize codes only
   task cmd(input [7:0] code, input [15:0] feat, input [15:0] cnt, input [31:0] pat);
   begin
      @(negedge i_clk);
      i_cmd_valid = 1'b1;
      i_command = code;
      i_feature = feat;
      i_count = cnt;
      {i_sect_num_prev, i_cyl_hi_cur, i_cyl_lo_cur, i_sect_num_cur} = pat;
      @(negedge i_clk);
      i_cmd_valid = 1'b0;
      check(o_cmd_done, code == 8'hb4);
   end
   endtask
   task abort(input [7:0] reason);
   begin
      check(o_command_error_flags, 8'h04);
      check(o_device_status_flags[0], 1);
      check(o_ret_sect_num, reason);
   end
   endtask
   // status command that succeeds with the given returned count
   task status(input [15:0] ret);
   begin
      cmd(8'hb4, 16'h0000, 16'h0000, 32'h0);
      check(o_command_error_flags, 8'h00);
      check(o_ret_count, ret);
      if (!ret[14])
         check({o_ret_cyl_lo, o_ret_sect_num}, 16'hffff);
   end
   endtask
   task wait_idle(input [31:0] exp_beats);
   begin
      for (n = 0; n < 70000 && o_wr_valid !== 1'b0; n = n + 1)
         @(negedge i_clk);
      @(negedge i_clk);
      check(beats - b0, exp_beats);
   end
   endtask
   task pulse(input integer which);
   begin
      @(negedge i_clk);
      if (which == 0) i_freeze_lock_done = 1'b1;
      if (which == 1) i_hard_reset = 1'b1;
      if (which == 2) i_por_event = 1'b1;
      @(negedge i_clk);
      {i_freeze_lock_done, i_hard_reset, i_por_event} = 3'b000;
   end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task t_two_pass;
   begin
      b0 = beats;
      cmd(8'hb4, 16'h0014, 16'h0092, 32'h12345678);
      check(o_ret_count[14], 1);
      wait_idle(32'd8192);
      check(pass_pat, 32'hedcba987);
      status(16'h8000);
      $display("test two_pass done");
   end
   endtask
   task t_fail_path;
   begin
      fault = 1'b1;
      b0 = beats;
      cmd(8'hb4, 16'h0014, 16'h0011, 32'h0);
      wait_idle(32'd4096);
      status(16'h0000);
      stall = 1'b1;
      fault = 1'b1;
      b0 = beats;
      cmd(8'hb4, 16'h0014, 16'h0001, 32'h0000aa55);
      repeat (100) @(negedge i_clk);
      status(16'h4000);
      p1 = {o_ret_cyl_lo, o_ret_sect_num};
      cmd(8'hb4, 16'h0014, 16'h0001, 32'h0);
      abort(8'h00);
      repeat (100) @(negedge i_clk);
      status(16'h4000);
      check({o_ret_cyl_lo, o_ret_sect_num} > p1, 1);
      wait_idle(32'd4096);
      stall = 1'b0;
      fault = 1'b0;
      cmd(8'hb4, 16'h0000, 16'h0000, 32'h0);
      abort(8'h01);
      cmd(8'hb4, 16'h0014, 16'h0011, 32'h0);
      abort(8'h00);
      b0 = beats;
      cmd(8'hb4, 16'h0014, 16'h0001, 32'h0f0f0f0f);
      check(o_ret_count[14], 1);
      wait_idle(32'd4096);
      status(16'h8000);
      $display("test fail_path done");
   end
   endtask
   task t_refusals;
   begin
      cmd(8'hb4, 16'h0011, 16'h0000, 32'h0);
      abort(8'h02);
      cmd(8'hb4, 16'h00ff, 16'h0000, 32'h0);
      abort(8'h02);
      cmd(8'hec, 16'h0014, 16'h0001, 32'h0);
      i_sanitize_supported = 1'b0;
      cmd(8'hb4, 16'h0014, 16'h0001, 32'h0);
      abort(8'h02);
      i_sanitize_supported = 1'b1;
      $display("test refusals done");
   end
   endtask
   task t_freeze;
   begin
      pulse(0);
      status(16'ha000);
      cmd(8'hb4, 16'h0014, 16'h0001, 32'h0);
      abort(8'h03);
      pulse(1);
      status(16'h8000);
      cmd(8'hb4, 16'h0014, 16'h0001, 32'h0);
      abort(8'h03);
      pulse(2);
      status(16'h8000);
      b0 = beats;
      cmd(8'hb4, 16'h0014, 16'h0000, 32'hc3c3c3c3);
      repeat (98) @(negedge i_clk);
      status(16'h4000);
      check({o_ret_cyl_lo, o_ret_sect_num}, 16'h0063);
      wait_idle(32'd65536);
      $display("test freeze done");
   end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial begin
      {i_clk, i_por_event, i_hard_reset, i_freeze_lock_done, i_cmd_valid} = 5'h00;
      {stall, fault, i_command, i_feature, i_count} = 42'h0;
      {i_sect_num_prev, i_cyl_hi_cur, i_cyl_lo_cur, i_sect_num_cur} = 32'h0;
      i_sanitize_supported = 1'b1;
      i_sys_rst = 1'b1;
      fail_count = 0;
      cmp_count = 0;
      repeat (10) @(negedge i_clk);
      i_sys_rst = 1'b0;
      check(o_command_error_flags, 8'h00);
      check(o_device_status_flags, 8'h40);
      check(o_ret_count, 16'h0000);
      check({o_ret_cyl_lo, o_ret_sect_num}, 16'hffff);
      t_two_pass;
      t_fail_path;
      t_refusals;
      t_freeze;
      complete_run;
   end
   initial begin
      #(100000 * 8);
      fail_count = fail_count + 1;
      complete_run;
   end
endmodule
